// file: dmate_pkg.sv
// Package for the DMA transfer termination block: register map, field
// positions, reset values and engine states.
// Assumes a 32-bit APB slave port and four channels sharing one engine.
package dmate_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W   = 2;

    // Register byte offsets; each channel owns a 16-byte window
    localparam logic [7:0] CH_STRIDE       = 8'h10;
    localparam logic [7:0] OFS_SOURCE_ADDR = 8'h00;
    localparam logic [7:0] OFS_DEST_ADDR   = 8'h04;
    localparam logic [7:0] OFS_COUNT       = 8'h08;
    localparam logic [7:0] OFS_CTRL        = 8'h0C;
    localparam logic [7:0] OFS_OPERATION   = 8'h40;

    // Channel control register fields
    localparam int CTL_CH_EN  = 0;
    localparam int CTL_IRQ_EN = 1;
    localparam int CTL_TEND   = 2;
    localparam int CTL_BURST  = 3;
    localparam int CTL_EDGE   = 4;
    localparam int CTL_SINGLE = 5;
    localparam int CTL_W      = 6;

    // Operation register fields
    localparam int OPR_MASTER_EN = 0;
    localparam int OPR_NMI       = 1;
    localparam int OPR_ADDR_ERR  = 2;

    // Reset values and address step per transfer unit
    localparam logic [31:0]      RST_WORD  = 32'h0000_0000;
    localparam logic [CTL_W-1:0] RST_CTRL  = 6'h00;
    localparam logic [31:0]      UNIT_STEP = 32'h0000_0004;
    localparam logic [31:0]      COUNT_ONE = 32'h0000_0001;

    // Engine states, Gray coded along idle -> read -> write -> end
    typedef enum logic [1:0] {
        DMATE_IDLE  = 2'b00,
        DMATE_READ  = 2'b01,
        DMATE_WRITE = 2'b11,
        DMATE_END   = 2'b10
    } dmate_state_t;
endpackage

// file: dmate_core.sv
// Transfer termination logic of a four-channel DMA engine with APB registers.
// Assumes requests, address-error and NMI inputs are synchronous to i_clk;
// a transfer unit is abstracted as a one-cycle read, a one-cycle write unless single, then an end cycle.
//
// Overview of operation
// - Level requester may drop request to pause.
// - Cycle steal: stop accepting, finish accepted, halt.
// - Edge burst: first request starts, same stop.
// - Burst stop bits sampled at request sampling points.
// - Burst request held pending until stop detected.
// - Suspend only at transfer unit boundary.
// - Dual mode: write follows read despite stop.
// - Channel ends on count zero or enable clear.
// - Count zero sets end flag at once.
// - End interrupt when irq enable set.
// - Enable clear suspends staged, end flag untouched.
// - All channels end on error, NMI, master off.
// - Address error suspends all, flags untouched.
// - Registers hold next addresses and remaining count.
// - Error flag cleared by read one, write zero.
// - External requests ignored while error/NMI set.
// - NMI sets flag and suspends all channels.
// - NMI flag cleared by read one, write zero.
// - Master enable clear suspends all channels.
// - Master enable set resumes from next transfer.
// - Acknowledge strobe one cycle per detection.

`timescale 1ns/1ps
`default_nettype none

module dmate_core
    import dmate_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // External requesters and system events
    input  wire logic [NUM_CH-1:0] i_ext_transfer_request,
    input  wire logic              i_addr_error,
    input  wire logic              i_nmi,
    // Transfer side
    output logic [NUM_CH-1:0]      o_request_ack_strobe,
    output logic [NUM_CH-1:0]      o_transfer_ack,
    output logic                   o_bus_busy,
    output logic                   o_write_phase,
    output logic [31:0]            o_bus_addr,
    output logic [NUM_CH-1:0]      o_transfer_end_irq
);

    dmate_state_t state_ff;
    dmate_state_t nxt_state;
    logic [CH_W-1:0]   act_ch_ff;
    logic [CH_W-1:0]   nxt_act_ch;
    logic [31:0]       src_ff [NUM_CH];
    logic [31:0]       dst_ff [NUM_CH];
    logic [31:0]       cnt_ff [NUM_CH];
    logic [CTL_W-1:0]  ctl_ff [NUM_CH];
    logic              master_en_ff;
    logic              nmi_flag_ff;
    logic              addr_err_flag_ff;
    logic              nmi_seen_ff;
    logic              err_seen_ff;
    logic [31:0]       rdata_ff;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] ch_ok;
    logic [NUM_CH-1:0] elig;
    logic [NUM_CH-1:0] accept;
    logic [NUM_CH-1:0] ack_ff;
    logic              all_ok;
    logic              unit_end;
    logic              last_unit;
    logic              wr_acc;
    logic              rd_acc;
    logic              rd_setup;
    logic [CH_W-1:0]   sel_ch;
    logic              ch_hit;
    logic              opr_hit;
    logic [31:0]       src_now;

    // APB decode; answers with zero wait states
    assign wr_acc   = i_psel & i_penable & i_pwrite;
    assign rd_acc   = i_psel & i_penable & ~i_pwrite;
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign sel_ch   = i_paddr[5:4];
    assign ch_hit   = (i_paddr[7:6] == 2'b00) & (i_paddr[1:0] == 2'b00);
    assign opr_hit  = (i_paddr == OFS_OPERATION);
    assign o_pready  = i_psel & i_penable;
    assign o_pslverr = i_psel & i_penable & ~(ch_hit | opr_hit);
    assign o_prdata  = rdata_ff;

    // Any flag or master-off condition stops every channel
    assign all_ok = master_en_ff & ~nmi_flag_ff & ~addr_err_flag_ff;

    // Unit boundary is the end state; nothing stops mid-unit
    assign unit_end  = (state_ff == DMATE_END);
    assign last_unit = (cnt_ff[act_ch_ff] == COUNT_ONE);

    // Per-channel request sampling, pending and burst run tracking
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            logic req_prev_ff;
            logic pend_ff;
            logic run_ff;
            logic samp;
            logic busy_here;
            logic done_here;

            assign ch_ok[c] = ctl_ff[c][CTL_CH_EN] & ~ctl_ff[c][CTL_TEND] & all_ok;
            assign busy_here = (state_ff != DMATE_IDLE) & (act_ch_ff == CH_W'(c));
            assign done_here = unit_end & (act_ch_ff == CH_W'(c));
            // No sampling while a request is held or a burst runs
            assign samp = ch_ok[c] & ~pend_ff & ~run_ff & ~busy_here;
            // Edge sensing takes a rising request, level sensing a high one;
            // an edge that comes while the channel is busy is not kept, so an
            // edge requester must drop its level and raise it again once the channel is free
            assign accept[c] = samp & i_ext_transfer_request[c]
                             & (~ctl_ff[c][CTL_EDGE] | ~req_prev_ff);
            assign pend[c] = pend_ff;
            assign run[c]  = run_ff;
            assign elig[c] = pend_ff | (run_ff & ch_ok[c]);

            // Previous request level for edge detection
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    req_prev_ff <= 1'b0;
                end else begin
                    req_prev_ff <= i_ext_transfer_request[c];
                end
            end

            // Accepted request stays until its unit completes
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    pend_ff <= 1'b0;
                end else if (accept[c]) begin
                    pend_ff <= 1'b1;
                end else if (done_here) begin
                    pend_ff <= 1'b0;
                end
            end

            // Edge burst keeps running until a stop is seen at a unit end;
            // master-off keeps it so that re-enabling resumes the burst
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    run_ff <= 1'b0;
                end else if (accept[c] & ctl_ff[c][CTL_BURST] & ctl_ff[c][CTL_EDGE]) begin
                    run_ff <= 1'b1;
                end else if (done_here & last_unit) begin
                    run_ff <= 1'b0;
                end else if (~busy_here & (~ctl_ff[c][CTL_CH_EN] | nmi_flag_ff
                             | addr_err_flag_ff)) begin
                    run_ff <= 1'b0;
                end
            end

            // End interrupt follows the end flag and its enable
            assign o_transfer_end_irq[c] = ctl_ff[c][CTL_TEND]
                                         & ctl_ff[c][CTL_IRQ_EN];
        end
    endgenerate

    // Acknowledge strobe: one cycle per detected request
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_ff <= '0;
        end else begin
            ack_ff <= accept;
        end
    end
    assign o_request_ack_strobe = ack_ff;

    // Engine next state; a started unit always runs its read, and its write unless single
    always_comb begin
        nxt_state  = state_ff;
        nxt_act_ch = act_ch_ff;
        unique case (state_ff)
            DMATE_IDLE: begin
                for (int i = NUM_CH - 1; i >= 0; i--) begin
                    if (elig[i]) begin
                        nxt_state  = DMATE_READ;
                        nxt_act_ch = CH_W'(i);
                    end
                end
            end
            DMATE_READ: begin
                // Stop conditions are not looked at here
                nxt_state = ctl_ff[act_ch_ff][CTL_SINGLE] ? DMATE_END : DMATE_WRITE;
            end
            DMATE_WRITE: begin
                nxt_state = DMATE_END;
            end
            DMATE_END: begin
                // Edge burst continues only while its stop bits are clear
                if (run[act_ch_ff] & ch_ok[act_ch_ff] & ~last_unit) begin
                    nxt_state = DMATE_READ;
                end else begin
                    nxt_state = DMATE_IDLE;
                end
            end
        endcase
    end

    // Engine state registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff  <= DMATE_IDLE;
            act_ch_ff <= '0;
        end else begin
            state_ff  <= nxt_state;
            act_ch_ff <= nxt_act_ch;
        end
    end

    // A burst unit that follows at once must not reuse the address that
    // is being stepped on this very edge, so take the stepped value then
    assign src_now = unit_end ? (src_ff[act_ch_ff] + UNIT_STEP)
                              : src_ff[nxt_act_ch];

    // Bus side outputs; bus returns to the CPU when idle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_transfer_ack <= '0;
            o_bus_busy     <= 1'b0;
            o_write_phase  <= 1'b0;
            o_bus_addr     <= RST_WORD;
        end else begin
            o_transfer_ack <= '0;
            if (nxt_state == DMATE_READ) begin
                o_transfer_ack[nxt_act_ch] <= 1'b1;
            end
            o_bus_busy    <= (nxt_state != DMATE_IDLE);
            o_write_phase <= (nxt_state == DMATE_WRITE);
            o_bus_addr    <= (nxt_state == DMATE_WRITE) ? dst_ff[nxt_act_ch]
                                                        : src_now;
        end
    end

    // Channel registers: software writes and unit-end updates
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                src_ff[i] <= RST_WORD;
                dst_ff[i] <= RST_WORD;
                cnt_ff[i] <= RST_WORD;
                ctl_ff[i] <= RST_CTRL;
            end
        end else begin
            if (wr_acc & ch_hit) begin
                unique case (i_paddr[3:0])
                    OFS_SOURCE_ADDR[3:0]: src_ff[sel_ch] <= i_pwdata;
                    OFS_DEST_ADDR[3:0]:   dst_ff[sel_ch] <= i_pwdata;
                    OFS_COUNT[3:0]:       cnt_ff[sel_ch] <= i_pwdata;
                    default:              ctl_ff[sel_ch] <= i_pwdata[CTL_W-1:0];
                endcase
            end
            if (unit_end) begin
                // Registers always point at the next unit
                src_ff[act_ch_ff] <= src_ff[act_ch_ff] + UNIT_STEP;
                dst_ff[act_ch_ff] <= dst_ff[act_ch_ff] + UNIT_STEP;
                cnt_ff[act_ch_ff] <= cnt_ff[act_ch_ff] - COUNT_ONE;
                if (last_unit) begin
                    ctl_ff[act_ch_ff][CTL_TEND] <= 1'b1;
                end
            end
        end
    end

    // Operation register: master enable and sticky event flags
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            master_en_ff     <= 1'b0;
            nmi_flag_ff      <= 1'b0;
            addr_err_flag_ff <= 1'b0;
            nmi_seen_ff      <= 1'b0;
            err_seen_ff      <= 1'b0;
        end else begin
            if (wr_acc & opr_hit) begin
                master_en_ff <= i_pwdata[OPR_MASTER_EN];
                // Clear needs a prior read of 1; a written 1 does nothing
                if (!i_pwdata[OPR_NMI] && nmi_seen_ff) begin
                    nmi_flag_ff <= 1'b0;
                    nmi_seen_ff <= 1'b0;
                end
                if (!i_pwdata[OPR_ADDR_ERR] && err_seen_ff) begin
                    addr_err_flag_ff <= 1'b0;
                    err_seen_ff      <= 1'b0;
                end
            end
            // Arm a clear only from the value the read handed to software;
            // a flag that rose after the setup cycle was not seen yet
            if (rd_acc & opr_hit) begin
                nmi_seen_ff <= rdata_ff[OPR_NMI];
                err_seen_ff <= rdata_ff[OPR_ADDR_ERR];
            end
            // A new event wins over a clear in the same cycle
            if (i_nmi) begin
                nmi_flag_ff <= 1'b1;
            end
            if (i_addr_error) begin
                addr_err_flag_ff <= 1'b1;
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_ff <= RST_WORD;
        end else if (rd_setup) begin
            rdata_ff <= RST_WORD;
            if (opr_hit) begin
                rdata_ff[OPR_MASTER_EN] <= master_en_ff;
                rdata_ff[OPR_NMI]       <= nmi_flag_ff;
                rdata_ff[OPR_ADDR_ERR]  <= addr_err_flag_ff;
            end else if (ch_hit) begin
                unique case (i_paddr[3:0])
                    OFS_SOURCE_ADDR[3:0]: rdata_ff <= src_ff[sel_ch];
                    OFS_DEST_ADDR[3:0]:   rdata_ff <= dst_ff[sel_ch];
                    OFS_COUNT[3:0]:       rdata_ff <= cnt_ff[sel_ch];
                    default:              rdata_ff[CTL_W-1:0] <= ctl_ff[sel_ch];
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// file: dmate_core_sva.sv
// Checker for the DMA termination core, bound to its ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dmate_core_sva
    import dmate_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [NUM_CH-1:0] i_ext_transfer_request,
    input wire logic              i_addr_error,
    input wire logic              i_nmi,
    input wire logic [NUM_CH-1:0] o_request_ack_strobe,
    input wire logic [NUM_CH-1:0] o_transfer_ack,
    input wire logic              o_bus_busy,
    input wire logic              o_write_phase,
    input wire logic [NUM_CH-1:0] o_transfer_end_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // A unit is a read cycle, an optional write cycle, then an end cycle
    sequence s_read;
        (o_transfer_ack != 4'h0) && o_bus_busy && !o_write_phase;
    endsequence
    sequence s_end;
        o_bus_busy && !o_write_phase && (o_transfer_ack == 4'h0);
    endsequence
    property p_unit_whole;
        s_read |=> (o_write_phase ##1 s_end) or s_end;
    endproperty
    a_unit_whole: assert property (p_unit_whole)
        else $error("transfer unit cut short");
    property p_wr_after_rd;
        o_write_phase |-> $past(o_transfer_ack) != 4'h0;
    endproperty
    a_wr_after_rd: assert property (p_wr_after_rd)
        else $error("write cycle without read cycle");
    property p_ack_one;
        (o_request_ack_strobe & $past(o_request_ack_strobe)) == 4'h0;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("acknowledge strobe longer than one cycle");
    property p_ack_cause;
        (o_request_ack_strobe & ~$past(i_ext_transfer_request)) == 4'h0;
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge strobe without request");
    property p_ack_serve;
        (o_request_ack_strobe != 4'h0) |-> ##[1:16] (o_transfer_ack != 4'h0);
    endproperty
    a_ack_serve: assert property (p_ack_serve)
        else $error("accepted request not served");
    // Bus goes back within a few units after error or NMI
    property p_err_free;
        i_addr_error |-> ##[1:16] !o_bus_busy;
    endproperty
    a_err_free: assert property (p_err_free)
        else $error("bus kept after address error");
    property p_nmi_free;
        i_nmi |-> ##[1:16] !o_bus_busy;
    endproperty
    a_nmi_free: assert property (p_nmi_free)
        else $error("bus kept after nmi");
    // Clearing a flag takes two APB transfers, so three quiet cycles are safe
    property p_err_quiet;
        i_addr_error |=> ##1 (o_request_ack_strobe == 4'h0) [*3];
    endproperty
    a_err_quiet: assert property (p_err_quiet)
        else $error("request accepted with error flag set");
    property p_nmi_quiet;
        i_nmi |=> ##1 (o_request_ack_strobe == 4'h0) [*3];
    endproperty
    a_nmi_quiet: assert property (p_nmi_quiet)
        else $error("request accepted with nmi flag set");
    property p_irq_cause;
        (o_transfer_end_irq & ~$past(o_transfer_end_irq)) != 4'h0 |->
            $past(o_bus_busy) || ($past(i_psel) && $past(i_penable) && $past(i_pwrite));
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("end interrupt without transfer end");
endmodule
bind dmate_core dmate_core_sva dmate_core_sva_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_ext_transfer_request(i_ext_transfer_request),
    .i_addr_error(i_addr_error), .i_nmi(i_nmi), .o_request_ack_strobe(o_request_ack_strobe),
    .o_transfer_ack(o_transfer_ack), .o_bus_busy(o_bus_busy), .o_write_phase(o_write_phase),
    .o_transfer_end_irq(o_transfer_end_irq));
`default_nettype wire

// file: dmate_requester.sv
// Model of the external requesters: level requests, one per channel.
// Assumes the bench sets which channels want service and which pause.
`timescale 1ns/1ps
`default_nettype none
module dmate_requester
    import dmate_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // Scenario control
    input  wire logic [NUM_CH-1:0] i_want,
    input  wire logic [NUM_CH-1:0] i_pause,
    // Device side
    input  wire logic [NUM_CH-1:0] i_request_ack_strobe,
    output logic [NUM_CH-1:0]      o_ext_transfer_request
);
    logic [NUM_CH-1:0] drop_ff;
    // A pausing requester drops its level after the strobe until pausing ends
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            drop_ff <= {NUM_CH{1'b0}};
        end else begin
            drop_ff <= (drop_ff | (i_request_ack_strobe & i_pause)) & i_pause;
        end
    end
    // Level held while wanted; raising it again is the reissue
    assign o_ext_transfer_request = i_want & ~drop_ff;
endmodule
`default_nettype wire

// file: dma_transfer_termination_tb.sv
// Self-checking bench for the DMA termination core over APB.
// Assumes the requester model drives all four request pins.
`timescale 1ns/1ps
`default_nettype none
module dma_transfer_termination_tb;
    import dmate_pkg::*;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_addr_error = 1'b0, i_nmi = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, o_bus_addr;
    logic o_pready, o_pslverr, o_bus_busy, o_write_phase, slv;
    logic [3:0] i_ext_transfer_request, o_request_ack_strobe, o_transfer_ack;
    logic [3:0] o_transfer_end_irq, want = 4'h0, pause = 4'h0;
    int err_count = 0, num_checks = 0, n_ack = 0;
    dmate_core dmate_core_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_addr_error(i_addr_error),
        .i_ext_transfer_request(i_ext_transfer_request), .i_nmi(i_nmi),
        .o_request_ack_strobe(o_request_ack_strobe), .o_transfer_ack(o_transfer_ack),
        .o_bus_busy(o_bus_busy), .o_write_phase(o_write_phase), .o_bus_addr(o_bus_addr),
        .o_transfer_end_irq(o_transfer_end_irq));
    dmate_requester dmate_requester_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_want(want), .i_pause(pause),
        .i_request_ack_strobe(o_request_ack_strobe),
        .o_ext_transfer_request(i_ext_transfer_request));
    // 10 MHz bus clock
    always #50 i_clk = ~i_clk;
    // Strobes seen on channel 0, to show that an edge burst gets only one
    always @(posedge i_clk) begin
        if (o_request_ack_strobe[0]) begin
            n_ack <= n_ack + 1;
        end
    end
    // Verdict and end of run
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic timeout;
        err_count++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (n > 50) timeout();
        end while (o_pready !== 1'b1);
        q = o_prdata;
        slv = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // Bounded wait: k=0 for a strobe, k=1 for an end interrupt
    task automatic wt(input int k, input int c);
        int n;
        n = 0;
        while (((k == 0) ? o_request_ack_strobe[c] : o_transfer_end_irq[c]) !== 1'b1) begin
            @(posedge i_clk);
            n++;
            if (n > 200) timeout();
        end
    endtask
    // Channel starts at source 1000h and destination 2000h, irq enabled
    task automatic prog(input int c, input logic [31:0] cnt);
        logic [7:0] b;
        b = CH_STRIDE * 8'(c);
        wr(b + OFS_SOURCE_ADDR, 32'h0000_1000);
        wr(b + OFS_DEST_ADDR, 32'h0000_2000);
        wr(b + OFS_COUNT, cnt);
        wr(b + OFS_CTRL, 32'h0000_0003);
    endtask
    // Channel state after n units done and some left; bus must be free
    task automatic chkch(input int c, input int n, input int left, input logic [31:0] ctl);
        logic [7:0] b;
        b = CH_STRIDE * 8'(c);
        rdc(b + OFS_SOURCE_ADDR, 32'h0000_1000 + UNIT_STEP * 32'(n));
        rdc(b + OFS_DEST_ADDR, 32'h0000_2000 + UNIT_STEP * 32'(n));
        rdc(b + OFS_COUNT, 32'(left));
        rdc(b + OFS_CTRL, ctl);
        chk({31'h0, o_bus_busy}, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        // Written ones must not set the flags; unmapped place refused
        wr(OFS_OPERATION, 32'h0000_0007);
        rdc(OFS_OPERATION, 32'h0000_0001);
        rdc(8'h44, 32'h0);
        chk({31'h0, slv}, 32'h1);
        // Count runs to zero: end flag and interrupt
        prog(0, 32'h0000_0002);
        want <= 4'h1;
        wt(1, 0);
        chkch(0, 2, 0, 32'h0000_0007);
        // Requester pauses after the first strobe
        prog(1, 32'h0000_0003);
        pause <= 4'h2;
        want <= 4'h2;
        wt(0, 1);
        repeat (20) @(posedge i_clk);
        chkch(1, 1, 2, 32'h0000_0003);
        // Address error in mid-unit; flag cleared only after a read of one
        pause <= 4'h0;
        wt(0, 1);
        i_addr_error <= 1'b1;
        @(posedge i_clk);
        i_addr_error <= 1'b0;
        repeat (20) @(posedge i_clk);
        chkch(1, 2, 1, 32'h0000_0003);
        want <= 4'h0;
        wr(CH_STRIDE + OFS_COUNT, 32'h0000_0001);
        wr(OFS_OPERATION, 32'h0000_0001);
        rdc(OFS_OPERATION, 32'h0000_0005);
        wr(OFS_OPERATION, 32'h0000_0001);
        want <= 4'h2;
        wt(1, 1);
        chkch(1, 3, 0, 32'h0000_0007);
        // Master enable cleared mid-transfer, then set again
        prog(2, 32'h0000_0003);
        want <= 4'h4;
        wt(0, 2);
        wr(OFS_OPERATION, 32'h0000_0000);
        repeat (20) @(posedge i_clk);
        chkch(2, 1, 2, 32'h0000_0003);
        wr(OFS_OPERATION, 32'h0000_0001);
        wt(1, 2);
        chkch(2, 3, 0, 32'h0000_0007);
        // NMI suspends, flag cleared after read of one
        prog(3, 32'h0000_0002);
        want <= 4'h8;
        wt(0, 3);
        i_nmi <= 1'b1;
        @(posedge i_clk);
        i_nmi <= 1'b0;
        repeat (20) @(posedge i_clk);
        chkch(3, 1, 1, 32'h0000_0003);
        rdc(OFS_OPERATION, 32'h0000_0003);
        wr(OFS_OPERATION, 32'h0000_0001);
        wt(1, 3);
        chkch(3, 2, 0, 32'h0000_0007);
        // Edge burst, single address: one strobe, units back to back;
        // master-off stops it at a unit end and re-enabling resumes it
        prog(0, 32'h0000_0008);
        wr(OFS_CTRL, 32'h0000_003B);
        want <= 4'h1;
        wt(0, 0);
        @(posedge i_clk);
        chk(o_bus_addr, 32'h0000_1000);
        chk({28'h0, o_transfer_ack}, 32'h0000_0001);
        repeat (2) @(posedge i_clk);
        chk(o_bus_addr, 32'h0000_1004);
        chk({28'h0, o_transfer_ack}, 32'h0000_0001);
        wr(OFS_OPERATION, 32'h0000_0000);
        repeat (20) @(posedge i_clk);
        chkch(0, 3, 5, 32'h0000_003B);
        wr(OFS_OPERATION, 32'h0000_0001);
        wt(1, 0);
        chkch(0, 8, 0, 32'h0000_003F);
        chk(n_ack, 32'h0000_0003);
        print_verdict();
    end
endmodule
`default_nettype wire
